// ===== include/rml_pkg.sv
// Purpose: shared constants and types for the register map lock and checksum
// Assumes: 24-bit map registers, each one 32-bit Avalon word, index * 4 bytes
// Notes: lane 3 of every map word is unused and reads as zero
//
// Notes on behaviour
// - password field at the unlock code makes every writable map register writable
// - while unlocked the checksum interrupt status is held cleared
// - while unlocked no map checksum is computed
// - while locked all writes are ignored except to the lock/checksum, status and mask registers
// - while locked other map registers read back a fixed undefined pattern
// - locked: checksum runs continuously; interrupt only when its enable bit is set
// - password field is bits 23-16, read/write, power-on value is unlock code
// - 16-bit checksum over the writable map, shown in bits 15-0
// - checksum field is read-only, host writes never change it
// - while locked the checksum is refreshed every 16 modulator clock periods
// - checksum field is forced to zero while the unlock code is held
package rml_pkg;

   // lock field coding and layout
   localparam logic [7:0] UNLOCK_CODE = 8'ha5;
   localparam logic [7:0] PWD_RESET = 8'ha5;
   localparam int unsigned PWD_LSB = 16;
   localparam int unsigned PWD_MSB = 23;
   localparam int unsigned CRC_LSB = 0;
   localparam int unsigned CRC_MSB = 15;
   localparam logic [15:0] CRC_RESET = 16'h0000;

   // register indices; byte address is four times the index
   localparam logic [5:0] IDX_LOCK = 6'h1f;
   localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
   localparam logic [5:0] IDX_IRQ_MASK = 6'h21;

   // reset values and read answers
   localparam logic [23:0] CFG_RESET = 24'h000000;
   localparam logic [31:0] UNDEF_READ = 32'h0000_0000;
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;
   localparam logic [0:0] IRQ_RESET = 1'h0;

   // checksum refresh interval in modulator clock periods
   localparam int unsigned CRC_PERIODS = 16;

   // event bit positions in the status and mask words
   localparam int unsigned EV_CRC_CHANGE = 0;

   // checksum walk over the map
   typedef enum logic [1:0] {
      RML_IDLE = 2'b00,
      RML_WALK = 2'b01,
      RML_DONE = 2'b10
   } rml_walk_t;

endpackage : rml_pkg

// ===== src/rml_top.sv
// Purpose: register map with password lock and background 16-bit checksum
// Assumes: Avalon-MM slave with waitrequest, single clock CLK_SYS at 100 MHz;
//    the host keeps one access in flight at a time
// Notes: the modulator clock is an internal divide of CLK_SYS;
//    a refresh walk needs the map frozen, which the lock guarantees
//
// Added by the designer: register access over Avalon-MM.
`timescale 1ns/100ps

module rml_top #(
   parameter int unsigned N_REGS = 16,
   parameter int unsigned DIGITAL_MODULATOR_CLOCK_DIV = 4,
   parameter logic [15:0] CRC_POLY = 16'h1021,
   parameter logic [15:0] CRC_INIT = 16'hffff,
   parameter bit MSB_FIRST = 1'b1
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   output logic IRQ,
   output logic MAP_LOCKED,
   output logic [N_REGS*24-1:0] CFG_FLAT
);

   localparam int unsigned IDX_W = $clog2(N_REGS);
   localparam int unsigned DIV_W = (DIGITAL_MODULATOR_CLOCK_DIV > 1) ? $clog2(DIGITAL_MODULATOR_CLOCK_DIV) : 1;
   localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(DIGITAL_MODULATOR_CLOCK_DIV - 1);
   localparam logic [3:0] PER_LAST = 4'(rml_pkg::CRC_PERIODS - 1);
   localparam logic [IDX_W-1:0] IDX_LAST = IDX_W'(N_REGS - 1);
   localparam logic [5:0] N_REGS_6 = 6'(N_REGS);

   // the walk must end well before the next refresh tick
   if (N_REGS + 2 > rml_pkg::CRC_PERIODS * DIGITAL_MODULATOR_CLOCK_DIV) begin : g_chk_walk
      $error("checksum walk longer than the refresh interval");
   end
   // parameter ranges the index and divider logic can serve
   if (N_REGS < 2 || N_REGS > 31) begin : g_chk_regs
      $error("N_REGS must lie between 2 and 31");
   end
   if (DIGITAL_MODULATOR_CLOCK_DIV < 1) begin : g_chk_div
      $error("DIGITAL_MODULATOR_CLOCK_DIV must be at least 1");
   end
   // a generator without its constant term is not a usable polynomial
   if (CRC_POLY[0] != 1'b1) begin : g_chk_poly
      $error("CRC_POLY must have its lowest bit set");
   end

   // one 24-bit word folded into the running checksum, bit-serial loop
   function automatic logic [15:0] crc_word(
      input logic [15:0] crc_in,
      input logic [23:0] data
   );
      logic [15:0] c;
      logic b;
      c = crc_in;
      for (int i = 0; i < 24; i++) begin
         b = MSB_FIRST ? data[23-i] : data[i];
         if (c[15] ^ b) begin
            c = {c[14:0], 1'b0} ^ CRC_POLY;
         end else begin
            c = {c[14:0], 1'b0};
         end
      end
      return c;
   endfunction : crc_word

   // state
   logic [23:0] cfg_ff [N_REGS];
   logic [7:0] pwd_ff;
   logic [15:0] crc_ff;
   logic crc_valid_ff;
   logic [15:0] acc_ff;
   logic [IDX_W-1:0] widx_ff;
   rml_pkg::rml_walk_t walk_ff;
   logic [DIV_W-1:0] div_ff;
   logic [3:0] per_ff;
   logic stat_ff;
   logic mask_ff;
   logic irq_ff;
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic locked_ff;

   // next values
   logic [7:0] nxt_pwd;
   logic [15:0] nxt_crc;
   logic nxt_crc_valid;
   logic [15:0] nxt_acc;
   logic [IDX_W-1:0] nxt_widx;
   rml_pkg::rml_walk_t nxt_walk;
   logic [DIV_W-1:0] nxt_div;
   logic [3:0] nxt_per;
   logic nxt_stat;
   logic nxt_mask;
   logic nxt_irq;
   logic nxt_wait;
   logic [31:0] nxt_rdata;
   logic nxt_locked;

   // bus decode
   wire [5:0] acc_idx = AVS_ADDRESS[7:2];
   wire acc_req = AVS_READ | AVS_WRITE;
   wire take_rd = AVS_READ & wait_ff;
   wire commit_wr = AVS_WRITE & ~wait_ff;
   wire hit_lock = (acc_idx == rml_pkg::IDX_LOCK);
   wire hit_stat = (acc_idx == rml_pkg::IDX_IRQ_STAT);
   wire hit_mask = (acc_idx == rml_pkg::IDX_IRQ_MASK);
   wire hit_cfg = (acc_idx < N_REGS_6);
   wire [IDX_W-1:0] cfg_sel = acc_idx[IDX_W-1:0];
   wire [23:0] lane_mask = {{8{AVS_BYTEENABLE[2]}},
                            {8{AVS_BYTEENABLE[1]}},
                            {8{AVS_BYTEENABLE[0]}}};

   // lock state is decoded straight from the password field
   wire unlocked = (pwd_ff == rml_pkg::UNLOCK_CODE);
   wire cfg_wr = commit_wr & hit_cfg & unlocked;
   wire lock_wr = commit_wr & hit_lock & AVS_BYTEENABLE[2];
   wire stat_wr = commit_wr & hit_stat & AVS_BYTEENABLE[0];
   wire mask_wr = commit_wr & hit_mask & AVS_BYTEENABLE[0];

   // map registers: one write port per entry, gated by lock and lanes
   generate
      for (genvar g = 0; g < N_REGS; g++) begin : g_cfg
         wire sel = cfg_wr & (cfg_sel == IDX_W'(g));
         wire [23:0] nxt_cfg = sel ?
            ((cfg_ff[g] & ~lane_mask) | (AVS_WRITEDATA[23:0] & lane_mask)) :
            cfg_ff[g];
         always_ff @(posedge CLK_SYS or posedge RESET) begin
            if (RESET) begin
               cfg_ff[g] <= rml_pkg::CFG_RESET;
            end else begin
               cfg_ff[g] <= nxt_cfg;
            end
         end
         assign CFG_FLAT[g*24 +: 24] = cfg_ff[g];
      end
   endgenerate

   // password field; checksum lanes of the same word are never written
   assign nxt_pwd = lock_wr ? AVS_WRITEDATA[rml_pkg::PWD_MSB:rml_pkg::PWD_LSB]
                            : pwd_ff;

   // lock state as of the next edge; clears land together with the unlock
   wire unlock_next = (nxt_pwd == rml_pkg::UNLOCK_CODE);

   // read answers; locked map words show a fixed pattern, not their value
   wire [31:0] rd_lock = {8'h00, pwd_ff, crc_ff};
   wire [31:0] rd_cfg = unlocked ? {8'h00, cfg_ff[cfg_sel]}
                                 : rml_pkg::UNDEF_READ;
   wire [31:0] rd_stat = {31'h0000_0000, stat_ff};
   wire [31:0] rd_mask = {31'h0000_0000, mask_ff};

   // lock word decoded first so no map index can shadow it
   logic [31:0] rd_sel;
   always_comb begin
      if (hit_lock) begin
         rd_sel = rd_lock;
      end else if (hit_cfg) begin
         rd_sel = rd_cfg;
      end else if (hit_stat) begin
         rd_sel = rd_stat;
      end else if (hit_mask) begin
         rd_sel = rd_mask;
      end else begin
         rd_sel = rml_pkg::UNMAPPED_READ;
      end
   end
   assign nxt_rdata = take_rd ? rd_sel : rdata_ff;

   // one wait cycle per access: low for exactly one edge, then high again
   assign nxt_wait = ~(acc_req & wait_ff);

   // modulator clock divider and 16-period refresh tick, idle when unlocked
   wire dm_tick = (div_ff == DIV_LAST);
   wire upd_tick = dm_tick & (per_ff == PER_LAST) & ~unlocked;
   assign nxt_div = (unlocked | dm_tick) ? '0 : div_ff + 1'b1;
   assign nxt_per = unlocked ? 4'h0 :
                    dm_tick ? per_ff + 4'h1 :
                    per_ff;

   // checksum walk over the map words, one word per clock
   wire [15:0] acc_fold = crc_word(acc_ff, cfg_ff[widx_ff]);
   always_comb begin
      nxt_walk = walk_ff;
      nxt_widx = widx_ff;
      nxt_acc = acc_ff;
      case (walk_ff)
         rml_pkg::RML_IDLE: begin
            if (upd_tick) begin
               nxt_walk = rml_pkg::RML_WALK;
               nxt_widx = '0;
               nxt_acc = CRC_INIT;
            end
         end
         rml_pkg::RML_WALK: begin
            nxt_acc = acc_fold;
            nxt_widx = widx_ff + 1'b1;
            if (widx_ff == IDX_LAST) begin
               nxt_walk = rml_pkg::RML_DONE;
               nxt_widx = '0;
            end
         end
         rml_pkg::RML_DONE: begin
            nxt_walk = rml_pkg::RML_IDLE;
         end
         default: begin
            nxt_walk = rml_pkg::RML_IDLE;
         end
      endcase
      // an unlock abandons any walk in progress
      if (unlock_next) begin
         nxt_walk = rml_pkg::RML_IDLE;
         nxt_widx = '0;
         nxt_acc = CRC_INIT;
      end
   end

   // published checksum; a change against the last result is the event
   wire publish = (walk_ff == rml_pkg::RML_DONE) & ~unlocked;
   wire crc_change = publish & crc_valid_ff & (acc_ff != crc_ff);
   assign nxt_crc = unlock_next ? rml_pkg::CRC_RESET :
                    publish ? acc_ff :
                    crc_ff;
   assign nxt_crc_valid = unlock_next ? 1'b0 :
                          publish ? 1'b1 :
                          crc_valid_ff;

   // sticky status: set beats a same-cycle clear, unlock forces it clear
   wire stat_clr = stat_wr & AVS_WRITEDATA[rml_pkg::EV_CRC_CHANGE];
   assign nxt_stat = unlock_next ? 1'b0 :
                     crc_change ? 1'b1 :
                     stat_clr ? 1'b0 :
                     stat_ff;
   assign nxt_mask = mask_wr ? AVS_WRITEDATA[rml_pkg::EV_CRC_CHANGE]
                             : mask_ff;
   // the mask bit doubles as the checksum interrupt enable
   assign nxt_irq = nxt_stat & nxt_mask & ~unlock_next;
   assign nxt_locked = ~unlock_next;

   // bus handshake: waitrequest low for one cycle per access
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         wait_ff <= 1'b1;
      end else begin
         wait_ff <= nxt_wait;
      end
   end

   // read data, loaded at the taking edge and held until the next read
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         rdata_ff <= 32'h0000_0000;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // password and its decoded lock flag move on the same edge
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         pwd_ff <= rml_pkg::PWD_RESET;
         locked_ff <= 1'b0;
      end else begin
         pwd_ff <= nxt_pwd;
         locked_ff <= nxt_locked;
      end
   end

   // published checksum and whether a first result exists yet
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         crc_ff <= rml_pkg::CRC_RESET;
         crc_valid_ff <= 1'b0;
      end else begin
         crc_ff <= nxt_crc;
         crc_valid_ff <= nxt_crc_valid;
      end
   end

   // walk engine
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         walk_ff <= rml_pkg::RML_IDLE;
         widx_ff <= '0;
         acc_ff <= 16'h0000;
      end else begin
         walk_ff <= nxt_walk;
         widx_ff <= nxt_widx;
         acc_ff <= nxt_acc;
      end
   end

   // modulator divider and period count
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         div_ff <= '0;
         per_ff <= 4'h0;
      end else begin
         div_ff <= nxt_div;
         per_ff <= nxt_per;
      end
   end

   // sticky event status
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         stat_ff <= 1'b0;
      end else begin
         stat_ff <= nxt_stat;
      end
   end

   // event mask, writable while locked so the alarm can be armed
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         mask_ff <= 1'b0;
      end else begin
         mask_ff <= nxt_mask;
      end
   end

   // interrupt level, registered so the pin never glitches
   always_ff @(posedge CLK_SYS or posedge RESET) begin
      if (RESET) begin
         irq_ff <= rml_pkg::IRQ_RESET;
      end else begin
         irq_ff <= nxt_irq;
      end
   end

   // outputs straight from flip-flops
   assign AVS_READDATA = rdata_ff;
   assign AVS_WAITREQUEST = wait_ff;
   assign IRQ = irq_ff;
   assign MAP_LOCKED = locked_ff;

endmodule : rml_top

// ===== test/rml_monitor.sv
// Purpose: bus and lock checks on the register map block
// Assumes: single clock, one wait cycle per access
// Notes: the checksum event is hard to provoke, so only its gating is seen
`timescale 1ns/100ps

module rml_monitor #(
   parameter int unsigned N_REGS = 16
) (
   input wire logic CLK_SYS,
   input wire logic RESET,
   input wire logic [7:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   input wire logic [31:0] AVS_READDATA,
   input wire logic AVS_WAITREQUEST,
   input wire logic IRQ,
   input wire logic MAP_LOCKED,
   input wire logic [N_REGS*24-1:0] CFG_FLAT
);
   // decoded access phases
   logic [5:0] idx;
   logic done;
   logic lk_wr;
   assign idx = AVS_ADDRESS[7:2];
   assign done = ~AVS_WAITREQUEST;
   assign lk_wr = AVS_WRITE && done && idx == rml_pkg::IDX_LOCK
      && AVS_BYTEENABLE[2];

   default clocking dcb @(posedge CLK_SYS);
   endclocking
   default disable iff (RESET);

   // answer comes after one wait cycle and lasts one cycle
   a_wait_one:
      assert property ((AVS_READ || AVS_WRITE) && !done |=> done)
      else $error("access not answered after one wait");
   a_wait_pulse:
      assert property (done |=> !done)
      else $error("waitrequest low too long");
   a_lock_set:
      assert property (lk_wr && AVS_WRITEDATA[23:16] != rml_pkg::UNLOCK_CODE
         |-> ##[1:2] MAP_LOCKED) else $error("map not locked");
   a_lock_clear:
      assert property (lk_wr && AVS_WRITEDATA[23:16] == rml_pkg::UNLOCK_CODE
         |-> ##[1:2] !MAP_LOCKED) else $error("map not unlocked");
   a_irq_gated:
      assert property (!MAP_LOCKED |-> !IRQ)
      else $error("interrupt while unlocked");
   a_map_frozen:
      assert property (MAP_LOCKED && $past(MAP_LOCKED) |-> $stable(CFG_FLAT))
      else $error("map changed while locked");
   a_undef_read:
      assert property (AVS_READ && done && MAP_LOCKED && idx < N_REGS
         |-> AVS_READDATA == rml_pkg::UNDEF_READ) else $error("locked read");
   a_crc_cleared:
      assert property (AVS_READ && done && !MAP_LOCKED && idx == 6'h1f
         |-> AVS_READDATA[23:0] == 24'ha50000) else $error("checksum kept");
   a_lane_zero:
      assert property (AVS_READ && done |-> AVS_READDATA[31:24] == 8'h00)
      else $error("top lane not zero");

   // main scenarios
   c_lock: cover property (lk_wr);
   c_undef: cover property (AVS_READ && done && MAP_LOCKED);
   c_map_wr: cover property (AVS_WRITE && done && !MAP_LOCKED && idx == 0);
endmodule : rml_monitor

bind rml_top rml_monitor #(.N_REGS(N_REGS)) u_mon (.CLK_SYS(CLK_SYS),
   .RESET(RESET), .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
   .AVS_BYTEENABLE(AVS_BYTEENABLE), .AVS_READDATA(AVS_READDATA),
   .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ),
   .MAP_LOCKED(MAP_LOCKED), .CFG_FLAT(CFG_FLAT));

// ===== test/rml_host.sv
// Purpose: host processor model on the Avalon register port
// Assumes: slave answers whenever it likes; no cycle count assumed
// Notes: released address and data park at inverted values
`timescale 1ns/100ps

module rml_host (
   input wire logic clk,
   input wire logic waitreq,
   output logic [7:0] addr,
   output logic rd,
   output logic wr,
   output logic [31:0] wdata,
   output logic [3:0] be
);
   // idle bus at time zero
   initial begin
      addr = 8'h00;
      rd = 1'b0;
      wr = 1'b0;
      wdata = 32'h0;
      be = 4'h0;
   end

   // one access, held until waitrequest is seen low at an edge
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, input logic [3:0] b);
      @(posedge clk);
      rd <= !w;
      wr <= w;
      addr <= a;
      wdata <= d;
      be <= b;
      do @(posedge clk); while (waitreq !== 1'b0);
      rd <= 1'b0;
      wr <= 1'b0;
      addr <= ~a;
      wdata <= ~d;
   endtask : xfer
endmodule : rml_host

// ===== test/register_map_lock_and_checksum_bench.sv
// Purpose: self-checking run of lock, readback and checksum behaviour
// Assumes: small map and fast modulator divide to keep the run short
// Notes: read answers are matched in order against a queue of notes
`timescale 1ns/100ps

module register_map_lock_and_checksum_bench;
   localparam int unsigned NR = 4;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   wire [7:0] adr;
   wire rd, wr, wreq, irq, locked;
   wire [31:0] wd, rdata;
   wire [3:0] be;
   wire [NR*24-1:0] cfg;
   logic [31:0] expq[$];
   logic [23:0] shadow[NR];
   logic [23:0] v;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;

   always #5 clk_sys = ~clk_sys;

   rml_host host (.clk(clk_sys), .waitreq(wreq), .addr(adr), .rd(rd),
      .wr(wr), .wdata(wd), .be(be));
   rml_top #(.N_REGS(NR), .DIGITAL_MODULATOR_CLOCK_DIV(2)) dut (.CLK_SYS(clk_sys),
      .RESET(reset), .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wd), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
      .AVS_WAITREQUEST(wreq), .IRQ(irq), .MAP_LOCKED(locked),
      .CFG_FLAT(cfg));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED t=%0t got %h want %h", $time, seen, exp);
      end
   endtask : chk

   task print_verdict();
      $display("mismatches %0d compares %0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : print_verdict

   task rd_exp(input logic [7:0] a, input logic [31:0] e);
      expq.push_back(e);
      host.xfer(1'b0, a, 32'h0, 4'hf);
   endtask : rd_exp

   // reference checksum, msb first over words in index order
   function automatic logic [15:0] crc_f();
      logic [15:0] c;
      c = 16'hffff;
      for (int w = 0; w < NR; w++)
         for (int i = 23; i >= 0; i--)
            c = {c[14:0], 1'b0} ^ ((c[15] ^ shadow[w][i]) ? 16'h1021 : 16'h0);
      return c;
   endfunction : crc_f

   // each read answer takes the oldest note
   always @(posedge clk_sys) begin
      if (rd === 1'b1 && wreq === 1'b0) begin
         if (expq.size() > 0) chk(rdata, expq.pop_front());
         else chk(32'(expq.size()), 32'h1);
      end
   end

   // ceiling well above the roughly 120 cycles needed
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         print_verdict();
      end
   end

   initial begin
      void'($urandom(32'h1ab4));
      foreach (shadow[i]) shadow[i] = 24'h0;
      repeat (3) @(posedge clk_sys);
      reset <= 1'b0;
      rd_exp(8'h7c, 32'h00a50000);
      v = 24'($urandom);
      shadow[0] = v;
      host.xfer(1'b1, 8'h00, {8'($urandom), v}, 4'hf);
      shadow[1] = 24'h00ffff;
      host.xfer(1'b1, 8'h04, 32'hffffffff, 4'h3);
      rd_exp(8'h00, {8'h0, v});
      rd_exp(8'h04, 32'h0000ffff);
      // lock with checksum lanes written too; they must not stick
      host.xfer(1'b1, 8'h7c, 32'hff3cffff, 4'hf);
      repeat (2) @(posedge clk_sys);
      #1 chk({31'h0, locked}, 32'h1);
      rd_exp(8'h7c, 32'h003c0000);
      host.xfer(1'b1, 8'h00, ~{8'h0, v}, 4'hf);
      rd_exp(8'h00, 32'h0);
      rd_exp(8'h88, 32'h0);
      host.xfer(1'b1, 8'h84, 32'h1, 4'hf);
      rd_exp(8'h84, 32'h1);
      host.xfer(1'b1, 8'h80, 32'h1, 4'hf);
      rd_exp(8'h80, 32'h0);
      repeat (60) @(posedge clk_sys);
      rd_exp(8'h7c, {16'h003c, crc_f()});
      #1 chk({31'h0, irq}, 32'h0);
      chk({8'h0, cfg[23:0]}, {8'h0, shadow[0]});
      host.xfer(1'b1, 8'h7c, 32'h00a51234, 4'h4);
      rd_exp(8'h7c, 32'h00a50000);
      rd_exp(8'h00, {8'h0, shadow[0]});
      @(posedge clk_sys);
      chk(32'(expq.size()), 32'h0);
      print_verdict();
   end
endmodule : register_map_lock_and_checksum_bench
